// >>> rtl/rid_pkg.sv
// Purpose: Shared constants, types and ALU helpers for the instruction decoder core
// Assumes: 13-bit instruction words, 8-bit data path, 14-bit program counter
// Notes: Status layout and vectors are used by the core and by the bench
package rid_pkg;

	localparam int PC_W = 14;
	localparam int INSTR_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int PCTL_NUM = 16;

	localparam logic [13:0] VEC_RESET = 14'h0000;
	localparam logic [13:0] VEC_SWI = 14'h0001;
	localparam logic [13:0] VEC_IRQ = 14'h0008;

	// Low-byte codes of the control group (upper bits all zero)
	localparam logic [7:0] CT_NOP = 8'h00;
	localparam logic [7:0] CT_DAA = 8'h01;
	localparam logic [7:0] CT_WRITE_CONTROL_REG = 8'h02;
	localparam logic [7:0] CT_ENTER_LOW_POWER = 8'h03;
	localparam logic [7:0] CT_CLEAR_WATCHDOG = 8'h04;
	localparam logic [7:0] CT_ENI = 8'h10;
	localparam logic [7:0] CT_GLOBAL_IRQ_OFF = 8'h11;
	localparam logic [7:0] CT_RET = 8'h12;
	localparam logic [7:0] CT_RETURN_FROM_IRQ = 8'h13;
	localparam logic [7:0] CT_READ_CONTROL_REG = 8'h14;
	localparam logic [7:0] CT_TBL = 8'h20;
	localparam logic [7:0] CT_CLEAR_ACC = 8'h80;
	localparam logic [3:0] CT_IOW_HI = 4'h0;
	localparam logic [3:0] CT_IOR_HI = 4'h1;

	// Register-operand groups, instruction bits 10..8
	localparam logic [2:0] GRP_CTL = 3'h0;
	localparam logic [2:0] GRP_SUB = 3'h1;
	localparam logic [2:0] GRP_ORAND = 3'h2;
	localparam logic [2:0] GRP_XORADD = 3'h3;
	localparam logic [2:0] GRP_MOVCOM = 3'h4;
	localparam logic [2:0] GRP_INCDJZ = 3'h5;
	localparam logic [2:0] GRP_ROT = 3'h6;
	localparam logic [2:0] GRP_SWAPJZ = 3'h7;

	// Literal groups, instruction bits 11..8 with bit 12 set
	localparam logic [3:0] LIT_MOV = 4'h8;
	localparam logic [3:0] LIT_OR = 4'h9;
	localparam logic [3:0] LIT_AND = 4'hA;
	localparam logic [3:0] LIT_XOR = 4'hB;
	localparam logic [3:0] LIT_RETURN_WITH_LITERAL = 4'hC;
	localparam logic [3:0] LIT_SUB = 4'hD;
	localparam logic [3:0] LIT_MISC = 4'hE;
	localparam logic [3:0] LIT_ADD = 4'hF;
	localparam logic [7:0] MISC_SWI = 8'h01;
	localparam logic [3:0] MISC_PAGE_HI = 4'h8;

	// Special register designators
	localparam logic [5:0] REG_PCL = 6'h02;
	localparam logic [5:0] REG_STATUS = 6'h03;
	localparam logic [5:0] REG_BANK = 6'h04;
	localparam logic [5:0] REG_PAGE = 6'h05;

	// Status register bit positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_P = 3;
	localparam int ST_T = 4;

	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] BANK_RST = 8'h00;
	localparam logic [3:0] PAGE_RST = 4'h0;
	localparam logic [7:0] CONTROL_REGISTER_RST = 8'hFF;
	localparam logic [7:0] PCTL_RST = 8'hFF;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] OPT_RST = 8'h00;

	// Code option word bit positions
	localparam int OPT_POVD_N = 0;
	localparam int OPT_MEM_LO = 1;
	localparam int OPT_MEM_HI = 2;
	localparam int OPT_ADC = 3;
	localparam int OPT_DAC = 4;
	localparam int OPT_TONE = 5;

	typedef enum logic {RID_RUN, RID_SLEEP} rid_state_t;

	typedef struct packed {
		logic povd_on;
		logic [1:0] memsize_sel;
		logic adc_block_on;
		logic dac_block_on;
		logic tone_block_on;
	} rid_opt_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic dc;
	} rid_alu_t;

	// x + y with carry and nibble carry
	function automatic rid_alu_t rid_add(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, x} + {1'b0, y};
		h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
		rid_add.res = s[7:0];
		rid_add.c = s[8];
		rid_add.dc = h[4];
	endfunction : rid_add

	// x - y; carry set means no borrow
	function automatic rid_alu_t rid_sub(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, x} - {1'b0, y};
		h = {1'b0, x[3:0]} - {1'b0, y[3:0]};
		rid_sub.res = s[7:0];
		rid_sub.c = ~s[8];
		rid_sub.dc = ~h[4];
	endfunction : rid_sub

endpackage : rid_pkg

// >>> rtl/rid_stack.sv
// Purpose: Circular return-address stack
// Assumes: Push and pop never asserted together
// Notes: Overflow wraps and overwrites the oldest entry
module rid_stack #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 14
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [WIDTH-1:0] push_data_i,
	output logic [WIDTH-1:0] top_o
);
	import rid_pkg::*;

	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("rid_stack DEPTH must be a power of two, at least 2");
	end

	logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
	logic [DEPTH-1:0][WIDTH-1:0] mem_next;
	logic [PW-1:0] ptr_reg;
	logic [PW-1:0] ptr_next;
	logic [PW-1:0] top_idx;

	assign top_idx = ptr_reg - PW'(1);
	assign top_o = mem_reg[top_idx];

	always_comb begin
		mem_next = mem_reg;
		ptr_next = ptr_reg;
		if (push_i) begin
			mem_next[ptr_reg] = push_data_i;
			ptr_next = ptr_reg + PW'(1);
		end else if (pop_i) begin
			ptr_next = top_idx;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mem_reg <= '0;
			ptr_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			ptr_reg <= ptr_next;
		end
	end

endmodule : rid_stack

// >>> rtl/rid_core.sv
// Purpose: Single-cycle fetch, decode and execute core for the 13-bit instruction set
// Assumes: Program memory returns instr_i combinationally for pmem_addr_o
// Notes: One instruction per clock; skipped words advance only the PC, sleep holds all state
module rid_core #(
	parameter int STACK_DEPTH = rid_pkg::STACK_DEPTH
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [rid_pkg::INSTR_W-1:0] instr_i,
	input wire logic irq_i,
	input wire logic wake_i,
	input wire logic [7:0] option_word_i,
	output logic [rid_pkg::PC_W-1:0] pmem_addr_o,
	output logic [7:0] acc_o,
	output logic [7:0] status_o,
	output logic [7:0] control_reg_o,
	output logic [rid_pkg::PCTL_NUM-1:0][7:0] port_ctrl_o,
	output logic global_irq_en_o,
	output logic wdt_clear_o,
	output logic irq_ack_o,
	output logic low_power_o,
	output rid_pkg::rid_opt_t option_o
);
	import rid_pkg::*;

	if (STACK_DEPTH < 2) begin : g_chk
		$error("rid_core STACK_DEPTH must be at least 2");
	end

	rid_state_t state_reg, state_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [7:0] acc_reg, acc_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] bank_reg, bank_next;
	logic [3:0] page_reg, page_next;
	logic [7:0] control_register_reg, control_register_next;
	logic [PCTL_NUM-1:0][7:0] pctl_reg, pctl_next;
	logic [255:0][7:0] file_reg, file_next;
	logic gie_reg, gie_next;
	logic skip_reg, skip_next;
	logic wdt_clr_reg, wdt_clr_next;
	logic irq_ack_reg, irq_ack_next;
	logic low_power_reg, low_power_next;
	rid_opt_t opt_reg, opt_next;
	logic opt_loaded_reg, opt_loaded_next;

	logic [PC_W-1:0] pc_inc;
	logic [PC_W-1:0] stack_top;
	logic push;
	logic pop;
	logic [PC_W-1:0] push_data;

	logic [12:0] ir;
	logic [5:0] r;
	logic [1:0] sel;
	logic [7:0] lit;
	logic [7:0] idx;
	logic [7:0] rv;
	logic [7:0] res;
	logic res_en;
	logic a_en;
	logic [7:0] a_val;
	logic wr_en;
	logic [7:0] wr_val;
	logic upd_z, upd_c, upd_dc;
	logic nc, ndc;
	logic [7:0] zval;
	rid_alu_t alu;
	logic [8:0] daa;
	logic [7:0] bmask;

	assign pc_inc = pc_reg + 14'h0001;

	rid_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(PC_W)
	) u_stack (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.push_i(push),
		.pop_i(pop),
		.push_data_i(push_data),
		.top_o(stack_top)
	);

	always_comb begin
		ir = instr_i;
		r = ir[5:0];
		sel = ir[7:6];
		lit = ir[7:0];
		idx = {bank_reg[7:6], r};
		case (r)
			REG_PCL: rv = pc_reg[7:0];
			REG_STATUS: rv = status_reg;
			REG_BANK: rv = bank_reg;
			REG_PAGE: rv = {4'h0, page_reg};
			default: rv = file_reg[idx];
		endcase
		bmask = 8'h01 << ir[8:6];
		state_next = state_reg;
		pc_next = pc_inc;
		acc_next = acc_reg;
		status_next = status_reg;
		bank_next = bank_reg;
		page_next = page_reg;
		control_register_next = control_register_reg;
		pctl_next = pctl_reg;
		file_next = file_reg;
		gie_next = gie_reg;
		skip_next = 1'b0;
		wdt_clr_next = 1'b0;
		irq_ack_next = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_data = pc_inc;
		res = 8'h00;
		res_en = 1'b0;
		a_en = 1'b0;
		a_val = 8'h00;
		wr_en = 1'b0;
		wr_val = 8'h00;
		upd_z = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		nc = 1'b0;
		ndc = 1'b0;
		zval = 8'h00;
		alu = '0;
		daa = 9'h000;
		// Option word is caught once after reset release, never through the data path
		opt_next = opt_reg;
		opt_loaded_next = 1'b1;
		if (!opt_loaded_reg) begin
			opt_next.povd_on = ~option_word_i[OPT_POVD_N];
			opt_next.memsize_sel = {option_word_i[OPT_MEM_HI], option_word_i[OPT_MEM_LO]};
			opt_next.adc_block_on = option_word_i[OPT_ADC];
			opt_next.dac_block_on = option_word_i[OPT_DAC];
			opt_next.tone_block_on = option_word_i[OPT_TONE];
		end
		case (state_reg)
			RID_SLEEP: begin
				pc_next = pc_reg;
				if (wake_i) begin
					state_next = RID_RUN;
				end
			end
			RID_RUN: begin
				if (skip_reg) begin
					pc_next = pc_inc;
				end else if (gie_reg && irq_i) begin
					push = 1'b1;
					push_data = pc_reg;
					pc_next = VEC_IRQ;
					gie_next = 1'b0;
					irq_ack_next = 1'b1;
				end else if (!ir[12] && ir[11]) begin
					case (ir[10:9])
						2'b00: begin
							wr_en = 1'b1;
							wr_val = rv & ~bmask;
						end
						2'b01: begin
							wr_en = 1'b1;
							wr_val = rv | bmask;
						end
						2'b10: skip_next = ((rv & bmask) == 8'h00);
						default: skip_next = ((rv & bmask) != 8'h00);
					endcase
				end else if (!ir[12]) begin
					case (ir[10:8])
						GRP_CTL: begin
							case (lit)
								CT_NOP: ;
								CT_DAA: begin
									daa = {1'b0, acc_reg};
									if (daa[3:0] > 4'h9 || status_reg[ST_DC]) begin
										daa = daa + 9'h006;
									end
									if (daa[7:4] > 4'h9 || status_reg[ST_C] || daa[8]) begin
										daa = daa + 9'h060;
									end
									a_en = 1'b1;
									a_val = daa[7:0];
									upd_c = 1'b1;
									nc = status_reg[ST_C] | daa[8];
								end
								CT_WRITE_CONTROL_REG: control_register_next = acc_reg;
								CT_READ_CONTROL_REG: begin
									a_en = 1'b1;
									a_val = control_register_reg;
								end
								CT_ENTER_LOW_POWER: begin
									wdt_clr_next = 1'b1;
									status_next[ST_T] = 1'b1;
									status_next[ST_P] = 1'b0;
									state_next = RID_SLEEP;
								end
								CT_CLEAR_WATCHDOG: begin
									wdt_clr_next = 1'b1;
									status_next[ST_T] = 1'b1;
									status_next[ST_P] = 1'b1;
								end
								CT_ENI: gie_next = 1'b1;
								CT_GLOBAL_IRQ_OFF: gie_next = 1'b0;
								CT_RET: begin
									pop = 1'b1;
									pc_next = stack_top;
								end
								CT_RETURN_FROM_IRQ: begin
									pop = 1'b1;
									pc_next = stack_top;
									gie_next = 1'b1;
								end
								CT_TBL: begin
									alu = rid_add(pc_reg[7:0], acc_reg);
									pc_next = {pc_reg[13:8], alu.res};
									zval = alu.res;
									nc = alu.c;
									ndc = alu.dc;
									upd_z = 1'b1;
									upd_c = 1'b1;
									upd_dc = 1'b1;
								end
								CT_CLEAR_ACC: begin
									a_en = 1'b1;
									upd_z = 1'b1;
								end
								default: begin
									if (lit[7:4] == CT_IOW_HI) begin
										pctl_next[lit[3:0]] = acc_reg;
									end else if (lit[7:4] == CT_IOR_HI) begin
										a_en = 1'b1;
										a_val = pctl_reg[lit[3:0]];
									end else if (sel == 2'b01) begin
										wr_en = 1'b1;
										wr_val = acc_reg;
									end else if (sel == 2'b11) begin
										wr_en = 1'b1;
										upd_z = 1'b1;
									end
								end
							endcase
						end
						GRP_SUB: begin
							res_en = 1'b1;
							upd_z = 1'b1;
							if (!sel[1]) begin
								alu = rid_sub(rv, acc_reg);
								res = alu.res;
								nc = alu.c;
								ndc = alu.dc;
								upd_c = 1'b1;
								upd_dc = 1'b1;
							end else begin
								res = rv - 8'h01;
							end
						end
						GRP_ORAND: begin
							res_en = 1'b1;
							upd_z = 1'b1;
							res = sel[1] ? (acc_reg & rv) : (acc_reg | rv);
						end
						GRP_XORADD: begin
							res_en = 1'b1;
							upd_z = 1'b1;
							alu = rid_add(acc_reg, rv);
							res = sel[1] ? alu.res : (acc_reg ^ rv);
							nc = alu.c;
							ndc = alu.dc;
							upd_c = sel[1];
							upd_dc = sel[1];
						end
						GRP_MOVCOM: begin
							res_en = 1'b1;
							upd_z = 1'b1;
							res = sel[1] ? ~rv : rv;
						end
						GRP_INCDJZ: begin
							res_en = 1'b1;
							res = sel[1] ? (rv - 8'h01) : (rv + 8'h01);
							upd_z = ~sel[1];
							skip_next = sel[1] && (res == 8'h00);
						end
						GRP_ROT: begin
							res_en = 1'b1;
							upd_c = 1'b1;
							res = sel[1] ? {rv[6:0], status_reg[ST_C]} : {status_reg[ST_C], rv[7:1]};
							nc = sel[1] ? rv[7] : rv[0];
						end
						default: begin
							res_en = 1'b1;
							res = sel[1] ? (rv + 8'h01) : {rv[3:0], rv[7:4]};
							skip_next = sel[1] && (res == 8'h00);
						end
					endcase
				end else if (ir[11:10] == 2'b00) begin
					push = 1'b1;
					pc_next = {page_reg, ir[9:0]};
				end else if (ir[11:10] == 2'b01) begin
					pc_next = {page_reg, ir[9:0]};
				end else begin
					case (ir[11:8])
						LIT_MOV: begin
							a_en = 1'b1;
							a_val = lit;
						end
						LIT_OR: begin
							a_en = 1'b1;
							a_val = acc_reg | lit;
							upd_z = 1'b1;
						end
						LIT_AND: begin
							a_en = 1'b1;
							a_val = acc_reg & lit;
							upd_z = 1'b1;
						end
						LIT_XOR: begin
							a_en = 1'b1;
							a_val = acc_reg ^ lit;
							upd_z = 1'b1;
						end
						LIT_RETURN_WITH_LITERAL: begin
							a_en = 1'b1;
							a_val = lit;
							pop = 1'b1;
							pc_next = stack_top;
						end
						LIT_SUB, LIT_ADD: begin
							alu = (ir[11:8] == LIT_SUB) ? rid_sub(lit, acc_reg) : rid_add(lit, acc_reg);
							a_en = 1'b1;
							a_val = alu.res;
							nc = alu.c;
							ndc = alu.dc;
							upd_z = 1'b1;
							upd_c = 1'b1;
							upd_dc = 1'b1;
						end
						default: begin
							if (lit == MISC_SWI) begin
								push = 1'b1;
								pc_next = VEC_SWI;
							end else if (lit[7:4] == MISC_PAGE_HI) begin
								page_next = lit[3:0];
							end
						end
					endcase
				end
			end
			default: state_next = RID_RUN;
		endcase
		// Register-group results go to the register when selector bit 0 is set
		if (res_en) begin
			zval = res;
			if (sel[0]) begin
				wr_en = 1'b1;
				wr_val = res;
			end else begin
				a_en = 1'b1;
				a_val = res;
			end
		end else if (a_en) begin
			zval = a_val;
		end else if (wr_en) begin
			zval = wr_val;
		end
		if (a_en) begin
			acc_next = a_val;
		end
		if (wr_en) begin
			case (r)
				REG_PCL: pc_next = {pc_reg[13:8], wr_val};
				REG_STATUS: status_next = wr_val;
				REG_BANK: bank_next = wr_val;
				REG_PAGE: page_next = wr_val[3:0];
				default: file_next[idx] = wr_val;
			endcase
		end
		// Flag updates follow any explicit write of the status register
		if (upd_z) begin
			status_next[ST_Z] = (zval == 8'h00);
		end
		if (upd_c) begin
			status_next[ST_C] = nc;
		end
		if (upd_dc) begin
			status_next[ST_DC] = ndc;
		end
		low_power_next = (state_next == RID_SLEEP);
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_reg <= RID_RUN;
			pc_reg <= VEC_RESET;
			acc_reg <= DATA_RST;
			status_reg <= STATUS_RST;
			bank_reg <= BANK_RST;
			page_reg <= PAGE_RST;
			control_register_reg <= CONTROL_REGISTER_RST;
			pctl_reg <= {PCTL_NUM{PCTL_RST}};
			file_reg <= '0;
			gie_reg <= 1'b0;
			skip_reg <= 1'b0;
			wdt_clr_reg <= 1'b0;
			irq_ack_reg <= 1'b0;
			low_power_reg <= 1'b0;
			opt_reg <= rid_opt_t'(OPT_RST[5:0]);
			opt_loaded_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			acc_reg <= acc_next;
			status_reg <= status_next;
			bank_reg <= bank_next;
			page_reg <= page_next;
			control_register_reg <= control_register_next;
			pctl_reg <= pctl_next;
			file_reg <= file_next;
			gie_reg <= gie_next;
			skip_reg <= skip_next;
			wdt_clr_reg <= wdt_clr_next;
			irq_ack_reg <= irq_ack_next;
			low_power_reg <= low_power_next;
			opt_reg <= opt_next;
			opt_loaded_reg <= opt_loaded_next;
		end
	end

	assign pmem_addr_o = pc_reg;
	assign acc_o = acc_reg;
	assign status_o = status_reg;
	assign control_reg_o = control_register_reg;
	assign port_ctrl_o = pctl_reg;
	assign global_irq_en_o = gie_reg;
	assign wdt_clear_o = wdt_clr_reg;
	assign irq_ack_o = irq_ack_reg;
	assign low_power_o = low_power_reg;
	assign option_o = opt_reg;

endmodule : rid_core

// >>> dv/rid_core_monitor.sv
// Purpose: Port checker for rid_core
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every rid_core instance
module rid_core_monitor #(
	parameter int STACK_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [12:0] instr_i,
	input wire logic irq_i,
	input wire logic wake_i,
	input wire logic [7:0] option_word_i,
	input wire logic [13:0] pmem_addr_o,
	input wire logic [7:0] acc_o,
	input wire logic [7:0] status_o,
	input wire logic [7:0] control_reg_o,
	input wire logic [15:0][7:0] port_ctrl_o,
	input wire logic global_irq_en_o,
	input wire logic wdt_clear_o,
	input wire logic irq_ack_o,
	input wire logic low_power_o,
	input wire rid_pkg::rid_opt_t option_o
);
	import rid_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_ctl_write: assert property ($past(nrst_i) && control_reg_o != $past(control_reg_o) |->
		$past(instr_i) == 13'h0002 && control_reg_o == $past(acc_o)) else $error("control reg changed without its code");
	a_port_write: assert property ($past(nrst_i) && port_ctrl_o != $past(port_ctrl_o) |->
		$past(instr_i[12:4]) == 9'h000 && port_ctrl_o[$past(instr_i[3:0])] == $past(acc_o))
		else $error("port control changed wrongly");
	a_wdt_cause: assert property (wdt_clear_o |->
		$past(nrst_i) && $past(instr_i) inside {13'h0003, 13'h0004}) else $error("watchdog clear without its code");
	a_sleep_entry: assert property ($rose(low_power_o) |->
		$past(instr_i) == 13'h0003 && wdt_clear_o && status_o[ST_T] && !status_o[ST_P]) else $error("bad sleep entry");
	a_sleep_hold: assert property (low_power_o && $past(low_power_o) |->
		$stable(pmem_addr_o) && $stable(acc_o)) else $error("state moved in sleep");
	a_wake_exit: assert property (low_power_o && wake_i |=> !low_power_o) else $error("no wake");
	a_irq_vector: assert property (irq_ack_o |-> pmem_addr_o == VEC_IRQ && !global_irq_en_o &&
		$past(irq_i) && $past(global_irq_en_o)) else $error("bad interrupt entry");
	a_gie_rise: assert property ($rose(global_irq_en_o) |->
		$past(instr_i) inside {13'h0010, 13'h0013}) else $error("irq enable set without its code");
	a_flags_keep: assert property ($past(nrst_i) && $past(instr_i) inside {[13'h0010:13'h0013]} |->
		status_o[2:0] == $past(status_o[2:0])) else $error("flags changed");
	a_opt_map: assert property ($past(nrst_i) && !$past(nrst_i, 2) |-> option_o == {~$past(option_word_i[0]),
		$past(option_word_i[2:1]), $past(option_word_i[3]), $past(option_word_i[4]), $past(option_word_i[5])})
		else $error("option map wrong");
	a_opt_fixed: assert property ($past(nrst_i) && $past(nrst_i, 2) |-> $stable(option_o)) else $error("option moved");
	c_sleep: cover property ($rose(low_power_o));
	c_irq: cover property (irq_ack_o);
	c_port: cover property ($past(nrst_i) && port_ctrl_o != $past(port_ctrl_o));
endmodule : rid_core_monitor

bind rid_core rid_core_monitor #(.STACK_DEPTH(STACK_DEPTH)) u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
	.instr_i(instr_i), .irq_i(irq_i), .wake_i(wake_i), .option_word_i(option_word_i), .pmem_addr_o(pmem_addr_o),
	.acc_o(acc_o), .status_o(status_o), .control_reg_o(control_reg_o), .port_ctrl_o(port_ctrl_o),
	.global_irq_en_o(global_irq_en_o), .wdt_clear_o(wdt_clear_o), .irq_ack_o(irq_ack_o),
	.low_power_o(low_power_o), .option_o(option_o));

// >>> dv/rid_pmem_model.sv
// Purpose: Program memory model answering fetches
// Assumes: Asynchronous read, word valid in the cycle of its address
// Notes: Unloaded words read as the idle code
module rid_pmem_model (
	input wire logic [13:0] addr_i,
	output logic [12:0] instr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] mem [0:16383];
	assign instr_o = mem[addr_i];
	task automatic clear();
		foreach (mem[i]) mem[i] = 13'h0000;
	endtask : clear
	task automatic put(input logic [13:0] a, input logic [12:0] w);
		mem[a] = w;
	endtask : put
endmodule : rid_pmem_model

// >>> dv/test_risc_instruction_decoder.sv
// Purpose: Self-checking bench for rid_core
// Assumes: Programs are loaded while reset is held, except the word t_flow puts at 0x0408 just after release
// Notes: Each program ends in a jump to itself; t_sleep_irq also reads results while asleep, before reaching it
module test_risc_instruction_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	import rid_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic irq_i = 1'b0;
	logic wake_i = 1'b0;
	logic [7:0] option_word_i = 8'h00;
	logic [12:0] instr;
	logic [13:0] pmem_addr_o;
	logic [7:0] acc_o, status_o, control_reg_o;
	logic [15:0][7:0] port_ctrl_o;
	logic global_irq_en_o, wdt_clear_o, irq_ack_o, low_power_o;
	rid_opt_t option_o;
	logic [12:0] prog[$];
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;

	rid_core #(.STACK_DEPTH(8)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .instr_i(instr), .irq_i(irq_i),
		.wake_i(wake_i), .option_word_i(option_word_i), .pmem_addr_o(pmem_addr_o), .acc_o(acc_o),
		.status_o(status_o), .control_reg_o(control_reg_o), .port_ctrl_o(port_ctrl_o),
		.global_irq_en_o(global_irq_en_o), .wdt_clear_o(wdt_clear_o), .irq_ack_o(irq_ack_o),
		.low_power_o(low_power_o), .option_o(option_o));
	rid_pmem_model u_pmem (.addr_i(pmem_addr_o), .instr_o(instr));

	initial forever #50 clk_i = ~clk_i;

	task automatic close_out();
		$display("Checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic run(input int n);
		repeat (n) @(negedge clk_i);
	endtask : run

	// Load prog from address 0 under reset, then release
	task automatic boot();
		nrst_i = 1'b0;
		u_pmem.clear();
		foreach (prog[i]) u_pmem.put(14'(i), prog[i]);
		run(6);
		nrst_i = 1'b1;
	endtask : boot

	task automatic t_literal();
		prog = '{13'h18F0, 13'h1F20, 13'h1D10, 13'h193C, 13'h1A0F, 13'h1B0C, 13'h1FA3, 13'h0001, 13'h1408};
		boot();
		run(20);
		chk(acc_o, 8'h03, "literal acc");
		chk(status_o, 8'h19, "literal status");
	endtask : t_literal

	task automatic t_regops();
		prog = '{13'h1881, 13'h0050, 13'h0610, 13'h1801, 13'h0051, 13'h05D1, 13'h1855, 13'h0AD1, 13'h0ED1,
			13'h1855, 13'h0411, 13'h140B};
		boot();
		run(20);
		chk(acc_o, 8'h08, "register acc");
		chk(status_o, 8'h19, "register status");
		chk(pmem_addr_o, 14'h000B, "register halt");
	endtask : t_regops

	task automatic t_flow();
		prog = '{13'h1403, 13'h0012, 13'h0000, 13'h1E01, 13'h1E81, 13'h1008, 13'h1E80, 13'h1407};
		boot();
		u_pmem.put(14'h0408, 13'h1C42);
		run(30);
		chk(acc_o, 8'h42, "flow acc");
		chk(pmem_addr_o, 14'h0007, "flow halt");
		chk(status_o, STATUS_RST, "flow status");
	endtask : t_flow

	// Register ALU ops, table jump, banking, increment skip, port read
	task automatic t_alu();
		prog = '{13'h1805, 13'h0050, 13'h1803, 13'h0150, 13'h0310, 13'h0390, 13'h0290, 13'h0020, 13'h1855,
			13'h0750, 13'h1840, 13'h0044, 13'h0410, 13'h04D0, 13'h07D0, 13'h1855, 13'h0510, 13'h0009,
			13'h0080, 13'h0019, 13'h1414};
		boot();
		run(30);
		chk(acc_o, 8'h01, "alu acc");
		chk(status_o, 8'h1C, "alu status");
		chk(port_ctrl_o[9], 8'h01, "alu port");
		chk(pmem_addr_o, 14'h0014, "alu halt");
	endtask : t_alu

	task automatic t_sleep_irq();
		prog = '{13'h18A5, 13'h0002, 13'h0007, 13'h1800, 13'h0014, 13'h0004, 13'h0003, 13'h1409, 13'h0013,
			13'h0010, 13'h140A};
		boot();
		for (int i = 0; i < 20 && low_power_o !== 1'b1; i++) run(1);
		chk(low_power_o, 1'b1, "sleep");
		chk(wdt_clear_o, 1'b1, "watchdog clear");
		chk(status_o[4:3], 2'b10, "sleep flags");
		chk(acc_o, 8'hA5, "control read");
		chk(control_reg_o, 8'hA5, "control write");
		chk(port_ctrl_o[7], 8'hA5, "port write");
		chk(port_ctrl_o[6], PCTL_RST, "port untouched");
		run(3);
		chk(pmem_addr_o, 14'h0007, "sleep hold");
		irq_i = 1'b1;
		wake_i = 1'b1;
		run(1);
		wake_i = 1'b0;
		for (int i = 0; i < 20 && irq_ack_o !== 1'b1; i++) run(1);
		chk(irq_ack_o, 1'b1, "irq taken");
		chk(pmem_addr_o, VEC_IRQ, "irq vector");
		chk(global_irq_en_o, 1'b0, "irq enable");
		chk(low_power_o, 1'b0, "woken");
		irq_i = 1'b0;
		run(1);
		chk(global_irq_en_o, 1'b1, "irq return enable");
		chk(pmem_addr_o, 14'h000A, "irq return address");
	endtask : t_sleep_irq

	task automatic t_option();
		logic [7:0] vals[5] = '{8'h00, 8'h3F, 8'h15, 8'h2A, 8'hC1};
		logic [5:0] exp;
		prog = '{13'h1400};
		foreach (vals[i]) begin
			option_word_i = vals[i];
			boot();
			run(2);
			exp = {~vals[i][0], vals[i][2:1], vals[i][3], vals[i][4], vals[i][5]};
			chk(option_o, exp, "option map");
			option_word_i = ~vals[i];
			run(3);
			chk(option_o, exp, "option fixed");
		end
	endtask : t_option

	initial begin
		u_pmem.clear();
		t_literal();
		t_regops();
		t_flow();
		t_alu();
		t_sleep_irq();
		t_option();
		close_out();
	end
endmodule : test_risc_instruction_decoder
